// ===== src/lcdcd_defs.vh
`ifndef LCDCD_DEFS_VH
`define LCDCD_DEFS_VH
// Register byte offsets
`define LCDCD_OFF_CMD 6'h00
`define LCDCD_OFF_DATA 6'h04
`define LCDCD_OFF_STATUS 6'h08
`define LCDCD_OFF_CFG 6'h0C
`define LCDCD_OFF_ADDR 6'h10
`define LCDCD_OFF_CTRL 6'h14
`define LCDCD_OFF_MODE 6'h18
// Command prefixes and opcodes
`define LCDCD_PFX_COL_LO 4'h0
`define LCDCD_PFX_COL_HI 4'h1
`define LCDCD_PFX_PAGE 4'hB
`define LCDCD_PFX_START 2'h1
`define LCDCD_OP_CONTRAST 8'h81
`define LCDCD_OP_REMAP 7'h50
`define LCDCD_OP_BIAS 7'h51
`define LCDCD_OP_ENTIRE 7'h52
`define LCDCD_OP_REVERSE 7'h53
`define LCDCD_OP_IND 7'h56
`define LCDCD_OP_DISP 7'h57
`define LCDCD_OP_SCAN_N 8'hC0
`define LCDCD_OP_SCAN_R 8'hC8
`define LCDCD_OP_RMW 8'hE0
`define LCDCD_OP_RESET 8'hE2
`define LCDCD_OP_NOP 8'hE3
`define LCDCD_OP_END 8'hEE
`define LCDCD_OP_TEST 8'hF0
`define LCDCD_OP_MUX 8'hA8
`define LCDCD_OP_XBIAS 8'hA9
// Reset values
`define LCDCD_RST_MUX 6'h3F
`define LCDCD_RST_XBIAS 2'h2
// Geometry
`define LCDCD_COLS 132
`define LCDCD_PAGES 9
`define LCDCD_ICON_PAGE 4'h8
`define LCDCD_COL_MAX 8'hFF
`define LCDCD_PAGE_MAX 4'h8
`endif

// ===== src/lcdcd_top.v
// Behaviour
// (RL1) Column address: two nibble commands, 8 bits
// (RL2) Page, high, low column commands precede data
// (RL3) Column advances on each data access
// (RL4) Start line register holds 0 to 63
// (RL5) Two-byte contrast command loads 6-bit register
// (RL6) Remap reverses column to segment order
// (RL7) Bias picks 1/7 or 1/9, 1/9 default
// (RL8) Entire-on lights all pixels, beats reverse
// (RL9) Reverse inverts pixels, never the icon line
// (RL10) Page address selects page 0 to 8
// (RL11) Read-modify-write saves column; reads hold it
// (RL12) End of read-modify-write restores column
// (RL13) Software reset clears listed settings
// (RL14) Indicator-on takes a following mode byte
// (RL15) Entire-on with display off enters power save
// (RL16) Indicator off: power save is sleep
// (RL17) Indicator on: power save is standby
// (RL18) Reset command in standby gives sleep
// (RL19) New command or reset pin exits power save
// (RL20) Command-side read returns status; not serial
// (RL21) Multiplex ratio programmable 2 to 64
// (RL22) RAM access independent of display mode
// (RL23) Column address saturates, never wraps
// (RL24) Host does a dummy read first
`timescale 1ns/1ns
`default_nettype none
`include "lcdcd_defs.vh"
module lcdcd_top #(
   parameter integer COLS = `LCDCD_COLS,
   parameter integer PAGES = `LCDCD_PAGES
) (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Pin
   input wire hardware_reset_pin_n,
   // AXI4-Lite write address
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Display scan port
   input wire [3:0] scan_page,
   input wire [7:0] scan_col,
   output reg [7:0] pixel_byte,
   // Settings to the drive logic
   output reg [5:0] contrast_level,
   output reg [5:0] start_line,
   output reg [5:0] mux_code,
   output reg seg_remap,
   output reg com_scan_reverse,
   output reg bias_sel_1_7,
   output reg [1:0] ext_bias,
   output reg display_on,
   output reg entire_on,
   output reg reverse_display,
   output reg indicator_on,
   output reg [1:0] indicator_mode,
   output reg test_mode,
   // Power state
   output reg sleep_mode,
   output reg standby_mode,
   output reg osc_enable,
   output reg drive_supply_enable,
   output reg outputs_at_supply
);

   localparam [1:0] PEND_NONE = 2'h0;
   localparam [1:0] PEND_CONTRAST = 2'h1;
   localparam [1:0] PEND_MUX = 2'h2;
   localparam [1:0] PEND_XBIAS = 2'h3;

   function [10:0] ram_index;
      input [3:0] page;
      input [7:0] col;
      begin
         ram_index = page * COLS[10:0] + {3'h0, col};
      end
   endfunction

   function in_range;
      input [3:0] page;
      input [7:0] col;
      begin
         in_range = (page <= `LCDCD_PAGE_MAX) && ({24'h0, col} < COLS);
      end
   endfunction

   reg [7:0] ram [0:COLS*PAGES-1];

   // Reset pin synchroniser, three stages
   reg pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
   always @(posedge mclk) begin
      if (sys_rst) begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
         pin_s3_reg <= 1'b1;
         pin_level_reg <= 1'b1;
      end else begin
         pin_s1_reg <= hardware_reset_pin_n;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         if (pin_s2_reg == pin_s3_reg) begin
            pin_level_reg <= pin_s3_reg;
         end
      end
   end
   wire hw_rst = sys_rst | ~pin_level_reg; // RL19

   // Decoder state
   reg [7:0] col_reg, col_saved_reg, rd_latch_reg;
   reg [3:0] page_reg;
   reg rmw_reg, serial_mode_reg, ind_pending_reg;
   reg [1:0] pend_reg;

   // Bus handshake
   wire wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   wire rd_fire = s_axi_arvalid & s_axi_arready;
   wire wr_cmd = wr_fire && s_axi_awaddr == `LCDCD_OFF_CMD && s_axi_wstrb[0];
   wire wr_data = wr_fire && s_axi_awaddr == `LCDCD_OFF_DATA
      && s_axi_wstrb[0];
   wire rd_data = rd_fire && s_axi_araddr == `LCDCD_OFF_DATA
      && !serial_mode_reg;
   wire [7:0] cb = s_axi_wdata[7:0];
   wire save_any = sleep_mode | standby_mode;
   wire [7:0] col_inc = (col_reg == `LCDCD_COL_MAX) ? col_reg
      : col_reg + 8'h01; // RL23

   function wmapped;
      input [5:0] a;
      begin
         wmapped = a == `LCDCD_OFF_CMD || a == `LCDCD_OFF_DATA
            || a == `LCDCD_OFF_CTRL;
      end
   endfunction

   function rmapped;
      input [5:0] a;
      begin
         rmapped = a == `LCDCD_OFF_CMD || a == `LCDCD_OFF_DATA
            || a == `LCDCD_OFF_STATUS || a == `LCDCD_OFF_CFG
            || a == `LCDCD_OFF_ADDR || a == `LCDCD_OFF_CTRL
            || a == `LCDCD_OFF_MODE;
      end
   endfunction

   always @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
               && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmapped(s_axi_awaddr) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Status byte
   wire [7:0] status_byte = {rmw_reg, display_on, save_any, standby_mode,
      reverse_display, entire_on, indicator_on, test_mode};

   always @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rmapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
               `LCDCD_OFF_CMD, `LCDCD_OFF_STATUS: s_axi_rdata <=
                  serial_mode_reg ? 32'h0 : {24'h0, status_byte}; // RL20
               `LCDCD_OFF_DATA: s_axi_rdata <=
                  serial_mode_reg ? 32'h0 : {24'h0, rd_latch_reg}; // RL24
               `LCDCD_OFF_CFG: s_axi_rdata <= {8'h0, mux_code,
                  start_line, 6'h0, contrast_level};
               `LCDCD_OFF_ADDR: s_axi_rdata <= {12'h0, page_reg, 8'h0,
                  col_reg};
               `LCDCD_OFF_CTRL: s_axi_rdata <= {31'h0, serial_mode_reg};
               `LCDCD_OFF_MODE: s_axi_rdata <= {20'h0, outputs_at_supply,
                  drive_supply_enable, osc_enable, indicator_mode,
                  ext_bias, bias_sel_1_7, com_scan_reverse, seg_remap,
                  sleep_mode, standby_mode};
               default: s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // RAM ports; host and scan never block each other
   always @(posedge mclk) begin
      if (wr_data && in_range(page_reg, col_reg)) begin
         ram[ram_index(page_reg, col_reg)] <= cb; // RL22
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         rd_latch_reg <= 8'h0;
      end else if (rd_data) begin
         // Pipelined read: the host sees the previous fetch
         rd_latch_reg <= in_range(page_reg, col_reg)
            ? ram[ram_index(page_reg, col_reg)] : 8'h0; // RL24
      end
   end

   // Pixel path for the drive logic
   wire [7:0] scan_c = seg_remap ? COLS[7:0] - 8'h01 - scan_col
      : scan_col; // RL6
   wire [7:0] scan_raw = in_range(scan_page, scan_c)
      ? ram[ram_index(scan_page, scan_c)] : 8'h0;
   always @(posedge mclk) begin
      if (sys_rst) begin
         pixel_byte <= 8'h0;
      end else if (entire_on) begin
         pixel_byte <= 8'hFF; // RL8
      end else if (reverse_display && scan_page != `LCDCD_ICON_PAGE) begin
         pixel_byte <= ~scan_raw; // RL9
      end else begin
         pixel_byte <= scan_raw; // RL9
      end
   end

   // Command decoder
   always @(posedge mclk) begin
      if (hw_rst) begin
         col_reg <= 8'h0;
         col_saved_reg <= 8'h0;
         page_reg <= 4'h0;
         rmw_reg <= 1'b0;
         pend_reg <= PEND_NONE;
         ind_pending_reg <= 1'b0;
         contrast_level <= 6'h0;
         start_line <= 6'h0;
         mux_code <= `LCDCD_RST_MUX;
         seg_remap <= 1'b0;
         com_scan_reverse <= 1'b0;
         bias_sel_1_7 <= 1'b0; // RL7
         ext_bias <= `LCDCD_RST_XBIAS;
         display_on <= 1'b0;
         entire_on <= 1'b0;
         reverse_display <= 1'b0;
         indicator_on <= 1'b0;
         indicator_mode <= 2'h0;
         test_mode <= 1'b0;
         sleep_mode <= 1'b0;
         standby_mode <= 1'b0;
      end else if (wr_cmd) begin
         if (save_any) begin
            // Any command leaves power save; reset in standby sleeps
            sleep_mode <= 1'b0; // RL19
            standby_mode <= 1'b0; // RL19
         end
         if (ind_pending_reg) begin
            indicator_mode <= cb[1:0]; // RL14
            ind_pending_reg <= 1'b0;
         end else if (pend_reg != PEND_NONE) begin
            case (pend_reg)
               PEND_CONTRAST: contrast_level <= cb[5:0]; // RL5
               PEND_MUX: mux_code <= cb[5:0]; // RL21
               PEND_XBIAS: ext_bias <= cb[1:0]; // RL7
               default: ext_bias <= ext_bias;
            endcase
            pend_reg <= PEND_NONE;
         end else if (cb[7:4] == `LCDCD_PFX_COL_LO) begin
            col_reg <= {col_reg[7:4], cb[3:0]}; // RL1 RL2
         end else if (cb[7:4] == `LCDCD_PFX_COL_HI) begin
            col_reg <= {cb[3:0], col_reg[3:0]}; // RL1 RL2
         end else if (cb[7:4] == `LCDCD_PFX_PAGE) begin
            page_reg <= (cb[3:0] > `LCDCD_PAGE_MAX) ? `LCDCD_PAGE_MAX
               : cb[3:0]; // RL10 RL2
         end else if (cb[7:6] == `LCDCD_PFX_START) begin
            start_line <= cb[5:0]; // RL4
         end else if (cb == `LCDCD_OP_CONTRAST) begin
            pend_reg <= PEND_CONTRAST; // RL5
         end else if (cb == `LCDCD_OP_MUX) begin
            pend_reg <= PEND_MUX; // RL21
         end else if (cb == `LCDCD_OP_XBIAS) begin
            pend_reg <= PEND_XBIAS;
         end else if (cb[7:1] == `LCDCD_OP_REMAP) begin
            seg_remap <= cb[0]; // RL6
         end else if (cb[7:1] == `LCDCD_OP_BIAS) begin
            bias_sel_1_7 <= cb[0]; // RL7
         end else if (cb[7:1] == `LCDCD_OP_REVERSE) begin
            reverse_display <= cb[0]; // RL9
         end else if (cb[7:1] == `LCDCD_OP_ENTIRE) begin
            entire_on <= cb[0]; // RL8
            if (cb[0] && !display_on) begin
               sleep_mode <= !indicator_on; // RL15 RL16
               standby_mode <= indicator_on; // RL15 RL17
            end
         end else if (cb[7:1] == `LCDCD_OP_DISP) begin
            display_on <= cb[0];
            if (!cb[0] && entire_on) begin
               sleep_mode <= !indicator_on; // RL15 RL16
               standby_mode <= indicator_on; // RL15 RL17
            end
         end else if (cb[7:1] == `LCDCD_OP_IND) begin
            indicator_on <= cb[0];
            ind_pending_reg <= cb[0]; // RL14
         end else if (cb == `LCDCD_OP_SCAN_N || cb == `LCDCD_OP_SCAN_R) begin
            com_scan_reverse <= cb[3];
         end else if (cb == `LCDCD_OP_RMW) begin
            if (!rmw_reg) begin
               col_saved_reg <= col_reg; // RL11
            end
            rmw_reg <= 1'b1; // RL11
         end else if (cb == `LCDCD_OP_END) begin
            if (rmw_reg) begin
               col_reg <= col_saved_reg; // RL12
            end
            rmw_reg <= 1'b0; // RL12
         end else if (cb == `LCDCD_OP_RESET) begin
            indicator_on <= 1'b0; // RL13
            start_line <= 6'h0; // RL13
            col_reg <= 8'h0; // RL13
            page_reg <= 4'h0; // RL13
            com_scan_reverse <= 1'b0; // RL13
            contrast_level <= 6'h0; // RL13
            test_mode <= 1'b0; // RL13
            if (standby_mode) begin
               sleep_mode <= 1'b1; // RL18
            end
         end else if (cb == `LCDCD_OP_TEST) begin
            test_mode <= 1'b1;
         end
      end else if (wr_data || rd_data) begin
         // Reads in read-modify-write keep the column
         if (wr_data || !rmw_reg) begin
            col_reg <= col_inc; // RL3 RL11
         end
      end
   end

   // Serial mode strap, software set
   always @(posedge mclk) begin
      if (sys_rst) begin
         serial_mode_reg <= 1'b0;
      end else if (wr_fire && s_axi_awaddr == `LCDCD_OFF_CTRL
            && s_axi_wstrb[0]) begin
         serial_mode_reg <= s_axi_wdata[0]; // RL20
      end
   end

   // Power outputs follow the mode flags a cycle later
   always @(posedge mclk) begin
      if (sys_rst) begin
         osc_enable <= 1'b1;
         drive_supply_enable <= 1'b1;
         outputs_at_supply <= 1'b0;
      end else begin
         osc_enable <= !sleep_mode; // RL16 RL17
         drive_supply_enable <= !(sleep_mode | standby_mode); // RL16
         outputs_at_supply <= sleep_mode | standby_mode; // RL16
      end
   end

endmodule // lcdcd_top
`default_nettype wire

// ===== tb/lcdcd_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module lcdcd_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic hardware_reset_pin_n,
   // Bus write side
   input wire logic [5:0] s_axi_awaddr,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   // Settings and power
   input wire logic [7:0] pixel_byte,
   input wire logic [5:0] contrast_level,
   input wire logic [5:0] start_line,
   input wire logic [5:0] mux_code,
   input wire logic com_scan_reverse,
   input wire logic display_on,
   input wire logic entire_on,
   input wire logic indicator_on,
   input wire logic test_mode,
   input wire logic sleep_mode,
   input wire logic standby_mode,
   input wire logic osc_enable,
   input wire logic drive_supply_enable,
   input wire logic outputs_at_supply
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic take, follow, cmd;
   // Command byte accepted in this cycle
   assign take = s_axi_awready && s_axi_wvalid && s_axi_wstrb[0]
      && s_axi_awaddr == 6'h00;
   // Second byte of a compound command is data, not a command
   always @(posedge mclk) begin
      if (sys_rst || !hardware_reset_pin_n) begin
         follow <= 1'b0;
      end else if (take) begin
         follow <= !follow && (s_axi_wdata[7:0] == 8'h81
            || s_axi_wdata[7:0] == 8'hA8 || s_axi_wdata[7:0] == 8'hA9
            || s_axi_wdata[7:0] == 8'hAD);
      end
   end
   assign cmd = take && !follow;
   AST_SLEEP_IND_OFF: assert property (sleep_mode |-> !indicator_on)
      else $error("sleep while indicator on");
   AST_STANDBY_IND_ON: assert property (standby_mode |-> indicator_on)
      else $error("standby while indicator off");
   AST_SLEEP_SUPPLY: assert property (sleep_mode && $past(sleep_mode)
      |-> !osc_enable && !drive_supply_enable && outputs_at_supply)
      else $error("sleep supplies wrong");
   AST_STANDBY_OSC: assert property (standby_mode
      && $past(standby_mode) |-> osc_enable && !drive_supply_enable
      && outputs_at_supply)
      else $error("standby oscillator wrong");
   AST_ENTIRE_PIX: assert property ($past(entire_on && display_on)
      |-> pixel_byte == 8'hFF)
      else $error("entire on not all pixels");
   AST_RESET_CMD: assert property (cmd && s_axi_wdata[7:0] == 8'hE2
      |=> contrast_level == 6'h00 && start_line == 6'h00
      && !com_scan_reverse && !test_mode && !indicator_on)
      else $error("software reset incomplete");
   AST_RESET_STANDBY: assert property (cmd && s_axi_wdata[7:0] == 8'hE2
      && standby_mode |=> sleep_mode)
      else $error("reset in standby not sleep");
   AST_ENTER_SAVE: assert property (cmd && s_axi_wdata[7:0] == 8'hA5
      && !display_on |=> sleep_mode || standby_mode)
      else $error("power save not entered");
   AST_CMD_EXIT: assert property (take && s_axi_wdata[7:0] == 8'hE3
      |=> !sleep_mode && !standby_mode)
      else $error("command did not exit power save");
   AST_PIN_EXIT: assert property ((!hardware_reset_pin_n) [*6]
      |-> !sleep_mode && !standby_mode && mux_code == 6'h3F)
      else $error("pin reset did not clear");
   COV_SLEEP: cover property (sleep_mode ##1 !sleep_mode);
   COV_STANDBY: cover property (standby_mode ##1 sleep_mode);
   COV_ENTIRE: cover property (entire_on && display_on);
endmodule // lcdcd_asserts
bind lcdcd_top lcdcd_asserts chk (.mclk, .sys_rst, .hardware_reset_pin_n,
   .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_awready,
   .pixel_byte, .contrast_level, .start_line, .mux_code, .com_scan_reverse,
   .display_on, .entire_on, .indicator_on, .test_mode, .sleep_mode,
   .standby_mode, .osc_enable, .drive_supply_enable, .outputs_at_supply);
`default_nettype wire

// ===== tb/lcdcd_host.sv
`timescale 1ns/1ns
`default_nettype none
module lcdcd_host (
   // Clock
   input wire logic mclk,
   // Write channels
   output logic [5:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // Read channels
   output logic [5:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end
   // Released lines show inverted values so stale data cannot pass
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      while (!s_axi_bvalid) @(posedge mclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      while (!s_axi_rvalid) @(posedge mclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule // lcdcd_host
`default_nettype wire

// ===== tb/test_lcd_command_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_lcd_command_decoder;
   logic mclk, sys_rst, hardware_reset_pin_n;
   logic [5:0] s_axi_awaddr, s_axi_araddr, contrast_level, start_line;
   logic [31:0] s_axi_wdata, s_axi_rdata, got;
   logic [3:0] s_axi_wstrb, scan_page;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, indicator_mode, ext_bias;
   logic drive_supply_enable, reverse_display;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, seg_remap, com_scan_reverse;
   logic [7:0] scan_col, pixel_byte;
   logic [5:0] mux_code;
   logic bias_sel_1_7, display_on, entire_on, indicator_on, test_mode;
   logic sleep_mode, standby_mode, osc_enable, outputs_at_supply;
   int failures, num_checks, cycles;
   lcdcd_top uut (.mclk, .sys_rst, .hardware_reset_pin_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scan_page,
      .scan_col, .pixel_byte, .contrast_level, .start_line, .mux_code,
      .seg_remap, .com_scan_reverse, .bias_sel_1_7, .ext_bias,
      .display_on, .entire_on, .reverse_display, .indicator_on,
      .indicator_mode, .test_mode, .sleep_mode, .standby_mode, .osc_enable,
      .drive_supply_enable, .outputs_at_supply);
   lcdcd_host host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) host.wr(6'h00, {24'h0, q[i]}, resp);
   endtask
   task automatic rd(input logic [5:0] a);
      host.rd(a, got, resp);
   endtask
   task automatic px(input logic [3:0] p, input logic [7:0] c, e);
      scan_page <= p;
      scan_col <= c;
      repeat (2) @(posedge mclk);
      `CHK(pixel_byte, e)
   endtask
   task automatic t_set;
      `CHK(bias_sel_1_7, 1'b0)
      `CHK(ext_bias, 2'h2)
      send('{8'h81, 8'h2A, 8'h7F, 8'hA8, 8'h00, 8'hA3, 8'hC8, 8'hF0});
      send('{8'hA9, 8'h01, 8'hAD, 8'h02});
      `CHK({contrast_level, start_line}, 12'hABF)
      `CHK(start_line, 6'h3F)
      `CHK(ext_bias, 2'h1)
      `CHK({mux_code, bias_sel_1_7}, 7'h01)
      `CHK({indicator_on, indicator_mode}, 3'h6)
      `CHK({com_scan_reverse, test_mode}, 2'h3)
      send('{8'hB2, 8'h13, 8'hE2});
      `CHK({contrast_level, start_line}, 12'h000)
      `CHK({com_scan_reverse, test_mode, indicator_on}, 3'h0)
      rd(6'h10);
      `CHK(got, 32'h0)
      $display("t_set done");
   endtask
   task automatic t_addr;
      send('{8'hB3, 8'h1A, 8'h05});
      rd(6'h10);
      `CHK(got, 32'h000300A5)
      host.wr(6'h04, 32'h5A, resp);
      rd(6'h10);
      `CHK(got, 32'h000300A6)
      send('{8'hE0});
      rd(6'h04);
      rd(6'h04);
      host.wr(6'h04, 32'h11, resp);
      rd(6'h10);
      `CHK(got, 32'h000300A7)
      send('{8'hEE});
      rd(6'h10);
      `CHK(got, 32'h000300A6)
      send('{8'hB8, 8'h1F, 8'h0F});
      host.wr(6'h04, 32'h77, resp);
      rd(6'h10);
      `CHK(got, 32'h000800FF)
      `CHK(got[19:16], 4'h8)
      $display("t_addr done");
   endtask
   task automatic t_ram;
      send('{8'hAF, 8'hA5, 8'hB0, 8'h10, 8'h00});
      `CHK({display_on, entire_on}, 2'h3)
      host.wr(6'h04, 32'h81, resp);
      host.wr(6'h04, 32'h3C, resp);
      send('{8'hB8, 8'h00});
      host.wr(6'h04, 32'h01, resp);
      send('{8'hB0, 8'h00});
      rd(6'h04);
      rd(6'h04);
      `CHK(got[7:0], 8'h81)
      rd(6'h04);
      `CHK(got[7:0], 8'h3C)
      $display("t_ram done");
   endtask
   task automatic t_pix;
      px(4'h8, 8'h05, 8'hFF);
      send('{8'hAE});
      `CHK(sleep_mode, 1'b1)
      send('{8'hA4, 8'hA6, 8'hA0});
      px(4'h0, 8'h00, 8'h81);
      send('{8'hA7});
      `CHK(reverse_display, 1'b1)
      px(4'h0, 8'h00, 8'h7E);
      px(4'h8, 8'h00, 8'h01);
      send('{8'hA1});
      `CHK(seg_remap, 1'b1)
      px(4'h0, 8'd131, 8'h7E);
      $display("t_pix done");
   endtask
   task automatic t_pwr;
      send('{8'hAE, 8'hAC, 8'hA5});
      host.wr(6'h04, 32'h55, resp);
      repeat (2) @(posedge mclk);
      `CHK({sleep_mode, standby_mode, outputs_at_supply}, 3'h5)
      `CHK({osc_enable, drive_supply_enable}, 2'h0)
      send('{8'hE3});
      `CHK({sleep_mode, standby_mode}, 2'h0)
      send('{8'hAD, 8'h01, 8'hA5});
      repeat (2) @(posedge mclk);
      `CHK({sleep_mode, standby_mode, outputs_at_supply}, 3'h3)
      `CHK({osc_enable, drive_supply_enable}, 2'h2)
      send('{8'hE2});
      `CHK({sleep_mode, standby_mode}, 2'h2)
      hardware_reset_pin_n <= 1'b0;
      repeat (8) @(posedge mclk);
      hardware_reset_pin_n <= 1'b1;
      // Let the pin filter settle before the next command
      repeat (4) @(posedge mclk);
      `CHK({sleep_mode, standby_mode, mux_code}, 8'h3F)
      `CHK(ext_bias, 2'h2)
      $display("t_pwr done");
   endtask
   task automatic t_stat;
      send('{8'hE0});
      rd(6'h00);
      `CHK(got[7:0], 8'h80)
      host.wr(6'h14, 32'h1, resp);
      `CHK(resp, 2'h0)
      rd(6'h00);
      `CHK(got, 32'h0)
      host.wr(6'h14, 32'h0, resp);
      send('{8'hEE});
      rd(6'h1C);
      `CHK(resp, 2'h2)
      host.wr(6'h08, 32'h0, resp);
      `CHK(resp, 2'h2)
      $display("t_stat done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      sys_rst = 1'b1;
      hardware_reset_pin_n = 1'b1;
      scan_page = 4'h0;
      scan_col = 8'h00;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      t_set();
      t_addr();
      t_ram();
      t_pix();
      t_pwr();
      t_stat();
      wrap_up();
   end
endmodule // test_lcd_command_decoder
`default_nettype wire
